/* File: src/reset_interrupt_vector_select.sv */
// Reset and interrupt vector address generator for the core's program counter
`timescale 1ns/10ps
`default_nettype none
`include "vector_select_cfg.svh"

// Notes on behaviour
// [RULE_01] Any system reset starts at address zero while the boot fuse is unprogrammed.
// [RULE_02] Source n vectors to table base plus n; reset is vector one.
// [RULE_03] A programmed boot fuse moves the reset start to the boot reset address.
// [RULE_04] Relocate bit set: each interrupt vector address adds the boot section start.
// [RULE_05] Fuse 1 is unprogrammed; fuse and relocate bit act independently.
// [RULE_06] A vector is fetched only when its interrupt is actually taken.
// [RULE_07] With a two-kilobyte boot section the boot reset address is 0xC00.
// [RULE_08] Several pending requests dispatch lowest vector number first.
module reset_interrupt_vector_select
  import vector_select_pkg::*;
#(
  parameter int                    SRC_N     = `VEC_SRC_N,
  parameter int                    ADDR_W    = `VEC_ADDR_W,
  parameter logic [`VEC_ADDR_W-1:0] BOOT_BASE = `VEC_BOOT_RESET
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              boot_reset_select_fuse,
  input  wire logic              vector_relocate_bit,
  input  wire logic [SRC_N-1:0]  irq_pending,
  input  wire logic              irq_global_enable,
  input  wire logic              core_ready,
  output logic                   fetch_valid,
  output logic [ADDR_W-1:0]      fetch_addr,
  output logic                   fetch_is_reset,
  output logic [`VEC_IDX_W-1:0]  irq_taken_index,
  output logic                   irq_ack
);

  // ----------------------------------------------------------------
  // Address arithmetic
  // ----------------------------------------------------------------
  // One word per source, so the index adds straight onto the table start.
  // Relocation only moves the base; the order of the table never changes.
  function automatic logic [ADDR_W-1:0] vec_addr(input logic [`VEC_IDX_W-1:0] idx,
                                                 input logic relocate);
    logic [ADDR_W-1:0] base;
    base = relocate ? BOOT_BASE : `VEC_RESET_ADDR; // RULE_04 RULE_07
    vec_addr = base + `VEC_TABLE_START + ADDR_W'(idx); // RULE_02
  endfunction

  function automatic logic [ADDR_W-1:0] reset_addr(input logic fuse);
    reset_addr = (fuse == `VEC_FUSE_UNPROG) ? `VEC_RESET_ADDR : BOOT_BASE; // RULE_01 RULE_03 RULE_05
  endfunction

  // ----------------------------------------------------------------
  // Request selection
  // ----------------------------------------------------------------
  logic                  pick_any;
  logic [`VEC_IDX_W-1:0] pick_idx;

  vector_priority_pick #(
    .SRC_N (SRC_N),
    .IDX_W (`VEC_IDX_W)
  ) u_pick (
    .request (irq_pending),
    .any     (pick_any),
    .index   (pick_idx)
  );

  // ----------------------------------------------------------------
  // Dispatch state
  // ----------------------------------------------------------------
  vec_state_t            state;
  vec_state_t            next_state;
  logic                  next_fetch_valid;
  logic [ADDR_W-1:0]     next_fetch_addr;
  logic                  next_fetch_is_reset;
  logic [`VEC_IDX_W-1:0] next_irq_taken_index;
  logic                  next_irq_ack;

  always_comb begin
    next_state           = state;
    next_fetch_valid     = fetch_valid;
    next_fetch_addr      = fetch_addr;
    next_fetch_is_reset  = fetch_is_reset;
    next_irq_taken_index = irq_taken_index;
    next_irq_ack         = 1'b0;
    unique case (state)
      ST_RESET: begin
        // Fuse is read after release, so the strap is never sampled under reset
        next_fetch_valid    = 1'b1;
        next_fetch_addr     = reset_addr(boot_reset_select_fuse); // RULE_01 RULE_03
        next_fetch_is_reset = 1'b1;
        next_state          = ST_DISPATCH;
      end
      ST_IDLE: begin
        // Nothing is fetched unless a request is enabled and taken
        if (irq_global_enable && pick_any) begin // RULE_06
          next_fetch_valid     = 1'b1;
          next_fetch_addr      = vec_addr(pick_idx, vector_relocate_bit); // RULE_04 RULE_08
          next_fetch_is_reset  = 1'b0;
          next_irq_taken_index = pick_idx;
          next_irq_ack         = 1'b1;
          next_state           = ST_DISPATCH;
        end
      end
      ST_DISPATCH: begin
        // Offer stands until taken; new requests wait so no vector is lost
        if (core_ready) begin
          next_fetch_valid    = 1'b0;
          next_fetch_is_reset = 1'b0;
          next_state          = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_RESET;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state           <= ST_RESET;
      fetch_valid     <= 1'b0;
      fetch_addr      <= `VEC_RESET_ADDR;
      fetch_is_reset  <= 1'b0;
      irq_taken_index <= '0;
      irq_ack         <= 1'b0;
    end else begin
      state           <= next_state;
      fetch_valid     <= next_fetch_valid;
      fetch_addr      <= next_fetch_addr;
      fetch_is_reset  <= next_fetch_is_reset;
      irq_taken_index <= next_irq_taken_index;
      irq_ack         <= next_irq_ack;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Reset fetch must lead every run, whatever the sources are doing
  chk_reset_zero_addr: assert property (@(posedge sys_clk) disable iff (rst) // RULE_01
    (state == ST_RESET && boot_reset_select_fuse)
    |=> fetch_is_reset && fetch_addr == `VEC_RESET_ADDR)
    else $error("reset fetch not at zero with fuse unprogrammed");

  chk_reset_boot_addr: assert property (@(posedge sys_clk) disable iff (rst) // RULE_03
    (state == ST_RESET && !boot_reset_select_fuse)
    |=> fetch_is_reset && fetch_addr == BOOT_BASE)
    else $error("reset fetch not at boot address with fuse programmed");

  chk_first_fetch_reset: assert property (@(posedge sys_clk) disable iff (rst) // RULE_01
    $fell(rst) |=> fetch_valid && fetch_is_reset)
    else $error("first fetch after reset is not the reset fetch");

  chk_reset_flag_clears: assert property (@(posedge sys_clk) disable iff (rst) // RULE_01
    (fetch_valid && fetch_is_reset && core_ready)
    |=> !fetch_valid && !fetch_is_reset)
    else $error("reset fetch outlived its acceptance");

  chk_vector_plain_map: assert property (@(posedge sys_clk) disable iff (rst) // RULE_02
    (state == ST_IDLE && irq_global_enable && pick_any && !vector_relocate_bit)
    |=> irq_ack && fetch_addr == ADDR_W'(irq_taken_index) + `VEC_TABLE_START)
    else $error("vector address not table entry");

  chk_last_vector: assert property (@(posedge sys_clk) disable iff (rst) // RULE_02
    (state == ST_IDLE && irq_global_enable && pick_any && !vector_relocate_bit
      && pick_idx == `VEC_IDX_W'(SRC_N - 1))
    |=> fetch_addr == `VEC_TABLE_START + ADDR_W'(SRC_N - 1))
    else $error("last source not at the end of the table");

  chk_vector_relocated: assert property (@(posedge sys_clk) disable iff (rst) // RULE_04
    (state == ST_IDLE && irq_global_enable && pick_any && vector_relocate_bit)
    |=> fetch_addr == BOOT_BASE + ADDR_W'(irq_taken_index) + `VEC_TABLE_START)
    else $error("relocated vector address wrong");

  chk_fuse_independent: assert property (@(posedge sys_clk) disable iff (rst) // RULE_05
    (state == ST_RESET && vector_relocate_bit && boot_reset_select_fuse)
    |=> fetch_addr == `VEC_RESET_ADDR)
    else $error("relocate bit moved the reset address");

  chk_fetch_only_taken: assert property (@(posedge sys_clk) disable iff (rst) // RULE_06
    (state == ST_IDLE && !(irq_global_enable && pick_any)) |=> !fetch_valid)
    else $error("fetch without a taken interrupt");

  chk_ack_with_fetch: assert property (@(posedge sys_clk) disable iff (rst) // RULE_06
    irq_ack |-> fetch_valid && !fetch_is_reset)
    else $error("acknowledge without an interrupt fetch");

  chk_busy_refuses: assert property (@(posedge sys_clk) disable iff (rst) // RULE_06
    (state == ST_DISPATCH) |=> !irq_ack)
    else $error("interrupt taken while a fetch was outstanding");

  chk_ack_pulse: assert property (@(posedge sys_clk) disable iff (rst) // RULE_06
    irq_ack |=> !irq_ack)
    else $error("acknowledge longer than one cycle");

  chk_boot_first_vector: assert property (@(posedge sys_clk) disable iff (rst) // RULE_07
    (state == ST_IDLE && irq_global_enable && irq_pending[0] && vector_relocate_bit)
    |=> fetch_addr == BOOT_BASE + `VEC_TABLE_START)
    else $error("first relocated vector not at boot base plus one");

  chk_lowest_first: assert property (@(posedge sys_clk) disable iff (rst) // RULE_08
    (state == ST_IDLE && irq_global_enable && irq_pending[0])
    |=> irq_ack && irq_taken_index == '0)
    else $error("lowest pending request not dispatched first");

  chk_dispatch_holds: assert property (@(posedge sys_clk) disable iff (rst)
    (fetch_valid && !core_ready) |=> fetch_valid && $stable(fetch_addr))
    else $error("fetch dropped before the core took it");

  // Scenarios worth seeing at least once
  cov_zero_reset:   cover property (@(posedge sys_clk) disable iff (rst)
    fetch_is_reset && fetch_addr == `VEC_RESET_ADDR);
  cov_boot_reset:   cover property (@(posedge sys_clk) disable iff (rst)
    fetch_is_reset && fetch_addr == BOOT_BASE);
  cov_plain_irq:    cover property (@(posedge sys_clk) disable iff (rst)
    irq_ack && !vector_relocate_bit);
  cov_reloc_irq:    cover property (@(posedge sys_clk) disable iff (rst)
    irq_ack && vector_relocate_bit);
  cov_last_source:  cover property (@(posedge sys_clk) disable iff (rst)
    irq_ack && irq_taken_index == `VEC_IDX_W'(SRC_N - 1));

endmodule
`default_nettype wire

/* File: src/vector_select_cfg.svh */
// Constants for the reset and interrupt vector address generator
`ifndef VECTOR_SELECT_CFG_SVH
`define VECTOR_SELECT_CFG_SVH
`define VEC_ADDR_W        12
`define VEC_SRC_N         25
`define VEC_IDX_W         5
`define VEC_RESET_ADDR    12'h000
`define VEC_TABLE_START   12'h001
`define VEC_BOOT_RESET    12'hC00
`define VEC_FUSE_UNPROG   1'b1
`define VEC_FUSE_PROG     1'b0
`endif

/* File: src/vector_select_pkg.sv */
// Types shared by the vector address generator
package vector_select_pkg;
  typedef enum logic [1:0] {
    ST_RESET    = 2'b00,
    ST_IDLE     = 2'b01,
    ST_DISPATCH = 2'b10
  } vec_state_t;
endpackage

/* File: src/vector_priority_pick.sv */
// Lowest-numbered pending request picker
`timescale 1ns/10ps
`default_nettype none
`include "vector_select_cfg.svh"
module vector_priority_pick #(
  parameter int SRC_N = `VEC_SRC_N,
  parameter int IDX_W = `VEC_IDX_W
) (
  input  wire logic [SRC_N-1:0] request,
  output logic                  any,
  output logic [IDX_W-1:0]      index
);
  always_comb begin
    any   = 1'b0;
    index = '0;
    // Walk downward so the lowest set bit is the one kept
    for (int i = SRC_N - 1; i >= 0; i--) begin
      if (request[i]) begin
        any   = 1'b1;
        index = IDX_W'(i); // RULE_08
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/core_fetch_model.sv */
// Processor core model that accepts vector fetches after a chosen stall
`timescale 1ns/10ps
`default_nettype none
module core_fetch_model (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       fetch_valid,
  input  wire logic [2:0] stall,
  output logic            core_ready
);
  logic [2:0] waited;
  // Ready is a one-cycle pulse, so a fresh offer is never accepted by a stale ready
  always_ff @(posedge sys_clk) begin
    if (rst || !fetch_valid || core_ready) begin
      waited     <= 3'h0;
      core_ready <= 1'b0;
    end else begin
      waited     <= waited + 3'h1;
      core_ready <= (waited == stall);
    end
  end
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the reset and interrupt vector address generator
`timescale 1ns/10ps
`default_nettype none
`include "vector_select_cfg.svh"
module tb_top;
  typedef struct packed {logic [24:0] p; logic r; logic [2:0] s; logic [4:0] k;} row_t;
  logic        sys_clk, rst, fuse, reloc, gen, core_ready, fetch_valid, is_reset, irq_ack;
  logic [24:0] pend;
  logic [2:0]  stall;
  logic [11:0] fetch_addr, exp;
  logic [4:0]  idx;
  int          fail_count, comparisons;
  row_t rows [7] = '{'{25'h000_0001, 1'b0, 3'h0, 5'h00}, '{25'h000_0008, 1'b1, 3'h2, 5'h03},
    '{25'h100_0000, 1'b0, 3'h4, 5'h18}, '{25'h100_0000, 1'b1, 3'h0, 5'h18},
    '{25'h000_0220, 1'b0, 3'h1, 5'h05}, '{25'h100_0002, 1'b1, 3'h0, 5'h01},
    '{25'h1FF_FFFF, 1'b0, 3'h0, 5'h00}};

  reset_interrupt_vector_select i_reset_interrupt_vector_select (.sys_clk(sys_clk), .rst(rst),
    .boot_reset_select_fuse(fuse), .vector_relocate_bit(reloc), .irq_pending(pend),
    .irq_global_enable(gen), .core_ready(core_ready), .fetch_valid(fetch_valid),
    .fetch_addr(fetch_addr), .fetch_is_reset(is_reset), .irq_taken_index(idx),
    .irq_ack(irq_ack));
  core_fetch_model i_core_fetch_model (.sys_clk(sys_clk), .rst(rst),
    .fetch_valid(fetch_valid), .stall(stall), .core_ready(core_ready));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] want);
    comparisons++;
    if (seen !== want) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic stop_test;
    if (fail_count == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Bounded wait for the offer to reach the given level
  task automatic wait_level(input logic lvl);
    int n;
    n = 0;
    while (fetch_valid !== lvl) begin
      @(posedge sys_clk);
      #1;
      n++;
      if (n > 20) begin
        fail_count++;
        stop_test();
      end
    end
  endtask

  task automatic do_reset(input logic f);
    @(posedge sys_clk);
    fuse <= f;
    rst <= 1'b1;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    check("idle_valid", {11'h000, fetch_valid}, 12'h000);
    wait_level(1'b1);
    check("reset_flag", {11'h000, is_reset}, 12'h001);
    check("reset_addr", fetch_addr, f ? `VEC_RESET_ADDR : `VEC_BOOT_RESET);
    wait_level(1'b0);
    check("reset_flag_end", {11'h000, is_reset}, 12'h000);
  endtask

  task automatic take(input row_t w);
    @(posedge sys_clk);
    pend <= w.p;
    reloc <= w.r;
    stall <= w.s;
    gen <= 1'b1;
    wait_level(1'b1);
    exp = (w.r ? `VEC_BOOT_RESET : `VEC_RESET_ADDR) + `VEC_TABLE_START + {7'h00, w.k};
    check("ack", {11'h000, irq_ack}, 12'h001);
    check("index", {7'h00, idx}, {7'h00, w.k});
    check("vector", fetch_addr, exp);
    check("irq_flag", {11'h000, is_reset}, 12'h000);
    @(posedge sys_clk);
    pend <= '0;
    gen <= 1'b0;
    #1;
    check("held", fetch_addr, exp);
    check("ack_end", {11'h000, irq_ack}, 12'h000);
    wait_level(1'b0);
  endtask

  initial begin
    fail_count = 0;
    comparisons = 0;
    {rst, fuse, reloc, gen, pend, stall} = {4'hC, 25'h000_0000, 3'h0};
    do_reset(1'b1);
    foreach (rows[i]) take(rows[i]);
    // ----------------------------------------------
    // Awkward cases
    // ----------------------------------------------
    @(posedge sys_clk);
    pend <= 25'h000_0010;
    repeat (10) @(posedge sys_clk);
    #1;
    check("masked", {11'h000, fetch_valid}, 12'h000);
    take(row_t'{25'h000_0010, 1'b0, 3'h0, 5'h04});
    for (int f = 0; f < 2; f++) begin
      for (int r = 0; r < 2; r++) begin
        do_reset(f[0]);
        take(row_t'{25'h000_0001, r[0], 3'h0, 5'h00});
      end
    end
    stop_test();
  end
endmodule
`default_nettype wire
